// >>> hw/cpc_regs.sv
// calibration, profile, trim and decimation register bank
`include "cpc_cfg.svh"
`default_nettype none
// What this block does
// - trim register resets to 4 mA setting
// - trim values scale feedback current down
// - target field picks slot for calibration results
// - every slot keeps own mixer settings
// - while idle, any of command bits 5:0 launches calibration routine, bits 7:6 are ignored
// - command clears on finish or abort
// - completion bit set when controller finishes
// - new command clears completion bit
// - write-only field picks operating slot
// - abort by writing one then zero
// - abort register reachable only during calibration
// - decimation codes map to 32/24/16/12
// - four mixer copies, slot 0 defaulted
module cpc_regs
(
    input  wire  logic                  clk_i,
    input  wire  logic                  rstn_i,
    input  wire  cpc_pkg::cpc_req_t     req_i,
    output logic [7:0]                  reg_rdata_o,
    output logic                        reg_rvalid_o,
    input  wire  logic                  mcu_done_i,
    output logic                        cal_start_o,
    output logic [`CPC_CMD_W-1:0]       cal_steps_o,
    output logic                        cal_busy_o,
    output logic                        cal_abort_o,
    output logic [1:0]                  cal_slot_o,
    output logic [7:0]                  trim_o,
    output logic [1:0]                  op_slot_o,
    output logic [2:0]                  dec_code_o,
    output logic [5:0]                  dec_factor_o,
    output cpc_pkg::cpc_mix_t           mixer_o
);

    cpc_pkg::cpc_state_t s_q;
    cpc_pkg::cpc_state_t s_d;
    cpc_pkg::cpc_mix_t   mix_tgt;
    logic                busy;
    logic                mem_we;
    logic [2:0]          mix_idx;

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic dec_valid(input logic [2:0] code);
        dec_valid = (code == `CPC_DEC_32) || (code == `CPC_DEC_24) ||
                    (code == `CPC_DEC_16) || (code == `CPC_DEC_12);
    endfunction

    function automatic logic [5:0] dec_factor(input logic [2:0] code);
        case (code)
            `CPC_DEC_32: dec_factor = `CPC_FAC_32;
            `CPC_DEC_24: dec_factor = `CPC_FAC_24;
            `CPC_DEC_16: dec_factor = `CPC_FAC_16;
            `CPC_DEC_12: dec_factor = `CPC_FAC_12;
            default:     dec_factor = `CPC_FAC_32;
        endcase
    endfunction

    function automatic logic is_mix(input logic [`CPC_AW-1:0] a);
        is_mix = (a >= `CPC_OFS_MIX0) && (a <= `CPC_OFS_MIXN);
    endfunction

    function automatic logic hit(input cpc_pkg::cpc_req_t r, input logic [`CPC_AW-1:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // register behaviour

    assign busy    = |s_q.cmd;
    assign mix_idx = 3'(req_i.addr - `CPC_OFS_MIX0);

    always_comb
    begin
        s_d         = s_q;
        s_d.start   = 1'b0;
        s_d.abort_p = 1'b0;
        s_d.rvalid  = 1'b0;
        mem_we      = 1'b0;
        if (req_i.wr && !busy)
        begin
            case (req_i.addr)
                `CPC_OFS_TRIM:   s_d.trim = req_i.wdata;
                `CPC_OFS_TGT:    s_d.tgt = req_i.wdata[1:0];
                `CPC_OFS_CMD:
                begin
                    if (|req_i.wdata[`CPC_CMD_W-1:0])
                    begin
                        s_d.cmd   = req_i.wdata[`CPC_CMD_W-1:0];
                        s_d.start = 1'b1;
                        s_d.done  = 1'b0;
                    end
                end
                `CPC_OFS_DONE:   s_d.done = req_i.wdata[0];
                `CPC_OFS_OPSLOT: s_d.opslot = req_i.wdata[1:0];
                `CPC_OFS_DEC:
                begin
                    if (dec_valid(req_i.wdata[2:0]))
                    begin
                        s_d.dec = req_i.wdata[2:0];
                    end
                end
                default:         mem_we = is_mix(req_i.addr);
            endcase
        end
        if (busy && hit(req_i, `CPC_OFS_ABORT))
        begin
            if (req_i.wdata[0])
            begin
                s_d.abort = 1'b1;
            end
            else if (s_q.abort)
            begin
                s_d.abort   = 1'b0;
                s_d.abort_p = 1'b1;
                s_d.cmd     = '0;
            end
        end
        if (busy && mcu_done_i)
        begin
            s_d.cmd   = '0;
            s_d.abort = 1'b0;
            s_d.done  = 1'b1;
        end
        if (req_i.rd)
        begin
            s_d.rvalid = 1'b1;
            case (req_i.addr)
                `CPC_OFS_TRIM:  s_d.rdata = s_q.trim;
                `CPC_OFS_TGT:   s_d.rdata = {6'h00, s_q.tgt};
                `CPC_OFS_CMD:   s_d.rdata = {2'h0, s_q.cmd};
                `CPC_OFS_DONE:  s_d.rdata = {7'h00, s_q.done};
                `CPC_OFS_ABORT: s_d.rdata = {7'h00, s_q.abort & busy};
                `CPC_OFS_DEC:   s_d.rdata = {5'h00, s_q.dec};
                default:        s_d.rdata = is_mix(req_i.addr) ? mix_tgt[mix_idx] : 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_q        <= '0;
            s_q.trim   <= `CPC_RST_TRIM;
            s_q.tgt    <= `CPC_RST_TGT;
            s_q.opslot <= `CPC_RST_OPSLOT;
            s_q.dec    <= `CPC_RST_DEC;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    cpc_slot_mem u_mem
    (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .we_i      (mem_we),
        .we_slot_i (s_q.tgt),
        .we_byte_i (mix_idx),
        .we_data_i (req_i.wdata),
        .a_slot_i  (s_q.tgt),
        .a_data_o  (mix_tgt),
        .b_slot_i  (s_q.opslot),
        .b_data_o  (mixer_o)
    );

    assign reg_rdata_o  = s_q.rdata;
    assign reg_rvalid_o = s_q.rvalid;
    assign cal_start_o  = s_q.start;
    assign cal_steps_o  = s_q.cmd;
    assign cal_busy_o   = busy;
    assign cal_abort_o  = s_q.abort_p;
    assign cal_slot_o   = s_q.tgt;
    assign trim_o       = s_q.trim;
    assign op_slot_o    = s_q.opslot;
    assign dec_code_o   = s_q.dec;
    assign dec_factor_o = dec_factor(s_q.dec);

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    launch_start_a: assert property (
        hit(req_i, `CPC_OFS_CMD) && !busy && |req_i.wdata[5:0]
        |=> cal_start_o && cal_busy_o && cal_steps_o == $past(req_i.wdata[5:0]) && !s_q.done)
        else $error("launch not taken");
    done_finish_a: assert property (
        busy && mcu_done_i |=> !cal_busy_o && s_q.done && !cal_start_o)
        else $error("finish not recorded");
    abort_seq_a: assert property (
        busy && s_q.abort && hit(req_i, `CPC_OFS_ABORT) && !req_i.wdata[0]
        |=> cal_abort_o && cal_steps_o == '0 ##1 !cal_abort_o)
        else $error("abort sequence failed");
    abort_idle_a: assert property (
        !busy |-> ##1 !cal_abort_o && !s_q.abort)
        else $error("abort active while idle");
    dec_map_a: assert property (
        (dec_code_o == 3'h1 && dec_factor_o == 6'd32) || (dec_code_o == 3'h2 && dec_factor_o == 6'd24)
        || (dec_code_o == 3'h3 && dec_factor_o == 6'd16) || (dec_code_o == 3'h4 && dec_factor_o == 6'd12))
        else $error("bad decimation mapping");
    dec_rsvd_a: assert property (
        hit(req_i, `CPC_OFS_DEC) && !dec_valid(req_i.wdata[2:0]) |=> $stable(dec_code_o))
        else $error("reserved code changed ratio");
    hold_trim_a: assert property (
        busy && hit(req_i, `CPC_OFS_TRIM) |=> $stable(trim_o))
        else $error("trim changed during calibration");
    trim_wr_a: assert property (
        !busy && hit(req_i, `CPC_OFS_TRIM) |=> trim_o == $past(req_i.wdata))
        else $error("trim write lost");
    tgt_wr_a: assert property (
        !busy && hit(req_i, `CPC_OFS_TGT) |=> cal_slot_o == $past(req_i.wdata[1:0]))
        else $error("target slot write lost");

    launch_c: cover property (cal_start_o ##[1:20] cal_busy_o && mcu_done_i);
    abort_c:  cover property (cal_abort_o);
    dec_c:    cover property (hit(req_i, `CPC_OFS_DEC) ##1 dec_code_o == 3'h4);

endmodule // cpc_regs
`default_nettype wire

// >>> hw/cpc_cfg.svh
// offsets, reset values and field codes of the calibration profile control registers
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH

`define CPC_AW          9
`define CPC_OFS_TRIM    9'h10a
`define CPC_OFS_TGT     9'h115
`define CPC_OFS_CMD     9'h116
`define CPC_OFS_DONE    9'h117
`define CPC_OFS_OPSLOT  9'h118
`define CPC_OFS_ABORT   9'h11a
`define CPC_OFS_DEC     9'h140
`define CPC_OFS_MIX0    9'h141
`define CPC_OFS_MIXN    9'h145

`define CPC_RST_TRIM    8'h40
`define CPC_RST_TGT     2'h0
`define CPC_RST_OPSLOT  2'h0
`define CPC_RST_DEC     3'h1
`define CPC_RST_MIX0    40'h00_0000_1505
`define CPC_RST_MIXN    40'h00_0000_0000

`define CPC_CMD_W       6
`define CPC_SLOTS       4
`define CPC_MIX_BYTES   5

`define CPC_DEC_32      3'h1
`define CPC_DEC_24      3'h2
`define CPC_DEC_16      3'h3
`define CPC_DEC_12      3'h4
`define CPC_FAC_32      6'h20
`define CPC_FAC_24      6'h18
`define CPC_FAC_16      6'h10
`define CPC_FAC_12      6'h0c

`endif

// >>> hw/cpc_pkg.sv
// types shared by the calibration profile control registers
`include "cpc_cfg.svh"
`default_nettype none
package cpc_pkg;

    // one register access from the serial control port
    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [`CPC_AW-1:0]  addr;
        logic [7:0]          wdata;
    } cpc_req_t;

    // mixer settings of one slot, byte 0 is the first mixer address
    typedef logic [`CPC_MIX_BYTES-1:0][7:0] cpc_mix_t;
    typedef cpc_mix_t [`CPC_SLOTS-1:0]      cpc_bank_t;

    typedef struct packed {
        cpc_bank_t bank;
        cpc_mix_t  rd_a;
        cpc_mix_t  rd_b;
    } cpc_mem_state_t;

    typedef struct packed {
        logic [7:0]           trim;
        logic [1:0]           tgt;
        logic [`CPC_CMD_W-1:0] cmd;
        logic                 done;
        logic [1:0]           opslot;
        logic                 abort;
        logic [2:0]           dec;
        logic [7:0]           rdata;
        logic                 rvalid;
        logic                 start;
        logic                 abort_p;
    } cpc_state_t;

endpackage
`default_nettype wire

// >>> hw/cpc_slot_mem.sv
// four-slot store of mixer tuning and initial phase settings
`include "cpc_cfg.svh"
`default_nettype none
module cpc_slot_mem
(
    input  wire  logic              clk_i,
    input  wire  logic              rstn_i,
    input  wire  logic              we_i,
    input  wire  logic [1:0]        we_slot_i,
    input  wire  logic [2:0]        we_byte_i,
    input  wire  logic [7:0]        we_data_i,
    input  wire  logic [1:0]        a_slot_i,
    output var   cpc_pkg::cpc_mix_t a_data_o,
    input  wire  logic [1:0]        b_slot_i,
    output var   cpc_pkg::cpc_mix_t b_data_o
);

    cpc_pkg::cpc_mem_state_t s_q;
    cpc_pkg::cpc_mem_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (we_i)
        begin
            s_d.bank[we_slot_i][we_byte_i] = we_data_i;
        end
        s_d.rd_a = s_q.bank[a_slot_i];
        s_d.rd_b = s_q.bank[b_slot_i];
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_q      <= '0;
            s_q.bank <= {{(`CPC_SLOTS-1){`CPC_RST_MIXN}}, `CPC_RST_MIX0};
            // both read ports start on slot 0, so they show its defaults
            s_q.rd_a <= `CPC_RST_MIX0;
            s_q.rd_b <= `CPC_RST_MIX0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign a_data_o = s_q.rd_a;
    assign b_data_o = s_q.rd_b;

    ////////////////////////////////////////////////////////////////////////////////
    slot_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        we_i |=> s_q.bank[$past(we_slot_i)][$past(we_byte_i)] == $past(we_data_i))
        else $error("slot byte not stored");

endmodule // cpc_slot_mem
`default_nettype wire

// >>> verification/cpc_regs_bench.sv
// self-checking bench of the calibration profile control register bank
`include "cpc_cfg.svh"
`default_nettype none
module cpc_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                  clk_i;
    logic                  rstn_i;
    cpc_pkg::cpc_req_t     req;
    logic                  mcu_done;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic                  start;
    logic [`CPC_CMD_W-1:0] steps;
    logic                  busy;
    logic                  abort;
    logic [1:0]            cslot;
    logic [7:0]            trim;
    logic [1:0]            oslot;
    logic [2:0]            dcode;
    logic [5:0]            dfac;
    cpc_pkg::cpc_mix_t     mix;
    int                    n_mismatch;
    int                    compares;
    int                    cycles;
    logic [7:0]            model [4][5];
    logic [7:0]            v;
    logic [7:0]            lt;
    logic [2:0]            cur;

    cpc_regs DUT (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .mcu_done_i(mcu_done), .cal_start_o(start),
        .cal_steps_o(steps), .cal_busy_o(busy), .cal_abort_o(abort), .cal_slot_o(cslot),
        .trim_o(trim), .op_slot_o(oslot), .dec_code_o(dcode), .dec_factor_o(dfac),
        .mixer_o(mix));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_i) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i) req <= '0;
        #1;
    endtask

    task automatic rdc(input string nm, input logic [8:0] a, input logic [7:0] e);
        @(posedge clk_i) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i) req <= '0;
        #1;
        chk({nm, " valid"}, 40'h1, rvalid);
        chk(nm, e, rdata);
    endtask

    task automatic launch(input logic [7:0] c);
        wr(`CPC_OFS_CMD, c);
        chk("start", 40'h1, start);
        chk("steps", c[5:0], steps);
        chk("busy", 40'h1, busy);
    endtask

    function automatic logic [5:0] fac(input logic [2:0] c);
        case (c)
            3'h2: return 6'h18;
            3'h3: return 6'h10;
            3'h4: return 6'h0c;
            default: return 6'h20;
        endcase
    endfunction

    function automatic logic [39:0] mexp(input int s);
        logic [39:0] m;
        for (int b = 0; b < 5; b++) m[b*8 +: 8] = model[s][b];
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn_i = 1'b0;
        req = '0;
        mcu_done = 1'b0;
        n_mismatch = 0;
        compares = 0;
        cycles = 0;
        void'($urandom(24));
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        chk("trim reset", `CPC_RST_TRIM, trim);
        chk("dec reset", 40'h1, dcode);
        chk("factor reset", 40'h20, dfac);
        chk("mixer reset", 40'h00_0000_1505, mix);
        rdc("trim read", `CPC_OFS_TRIM, 8'h40);
        rdc("opslot read", `CPC_OFS_OPSLOT, 8'h00);
        wr(9'h100, 8'hff);
        rdc("unmapped", 9'h100, 8'h00);
        rdc("abort idle", `CPC_OFS_ABORT, 8'h00);
        wr(`CPC_OFS_TGT, 8'h01);
        rdc("slot1 reset", `CPC_OFS_MIX0, 8'h00);
        $display("test reset finished");
        for (int i = 0; i < 6; i++)
        begin
            lt = (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : 8'h10 + 8'($urandom_range(48));
            wr(`CPC_OFS_TRIM, lt);
            chk("trim", lt, trim);
            rdc("trim read", `CPC_OFS_TRIM, lt);
        end
        $display("test trim finished");
        cur = 3'h1;
        for (int c = 0; c < 8; c++)
        begin
            wr(`CPC_OFS_DEC, 8'(c));
            if (c >= 1 && c <= 4) cur = 3'(c);
            chk("dec code", cur, dcode);
            chk("dec factor", fac(cur), dfac);
        end
        $display("test decimation finished");
        for (int s = 0; s < 4; s++)
        begin
            wr(`CPC_OFS_TGT, 8'(s));
            chk("cal slot", 40'(s), cslot);
            for (int b = 0; b < 5; b++)
            begin
                model[s][b] = 8'($urandom);
                wr(`CPC_OFS_MIX0 + 9'(b), model[s][b]);
            end
        end
        for (int s = 0; s < 4; s++)
        begin
            wr(`CPC_OFS_TGT, 8'(s));
            for (int b = 0; b < 5; b++) rdc("mix read", `CPC_OFS_MIX0 + 9'(b), model[s][b]);
            launch(8'h01);
            @(posedge clk_i) mcu_done <= 1'b1;
            @(posedge clk_i) mcu_done <= 1'b0;
            rdc("done slot", `CPC_OFS_DONE, 8'h01);
            wr(`CPC_OFS_OPSLOT, 8'(s));
            repeat (3) @(posedge clk_i);
            #1;
            chk("op slot", 40'(s), oslot);
            chk("mixer out", mexp(s), mix);
        end
        wr(`CPC_OFS_DONE, 8'h00);
        rdc("done host clear", `CPC_OFS_DONE, 8'h00);
        $display("test slots finished");
        wr(`CPC_OFS_CMD, 8'hc0);
        chk("no launch", 40'h0, busy);
        @(posedge clk_i) mcu_done <= 1'b1;
        @(posedge clk_i) mcu_done <= 1'b0;
        #1;
        rdc("done idle", `CPC_OFS_DONE, 8'h00);
        launch(8'(1 + $urandom_range(62)));
        wr(`CPC_OFS_TRIM, 8'h33);
        chk("trim held", lt, trim);
        @(posedge clk_i) mcu_done <= 1'b1;
        @(posedge clk_i) mcu_done <= 1'b0;
        #1;
        chk("steps clear", 40'h0, steps);
        chk("busy clear", 40'h0, busy);
        rdc("done set", `CPC_OFS_DONE, 8'h01);
        rdc("abort idle", `CPC_OFS_ABORT, 8'h00);
        $display("test finish finished");
        v = 8'h21;
        launch(v);
        rdc("done cleared", `CPC_OFS_DONE, 8'h00);
        wr(`CPC_OFS_CMD, 8'h3f);
        chk("cmd held", v[5:0], steps);
        rdc("abort busy", `CPC_OFS_ABORT, 8'h00);
        repeat (16) @(posedge clk_i);
        #1;
        chk("stalled", 40'h1, busy);
        wr(`CPC_OFS_ABORT, 8'h01);
        rdc("abort set", `CPC_OFS_ABORT, 8'h01);
        chk("still busy", 40'h1, busy);
        wr(`CPC_OFS_ABORT, 8'h00);
        chk("abort pulse", 40'h1, abort);
        chk("steps abort", 40'h0, steps);
        rdc("done abort", `CPC_OFS_DONE, 8'h00);
        $display("test abort finished");
        test_done();
    end
endmodule // cpc_regs_bench
`default_nettype wire
